//--- hdl/charger_termination_control.sv
// Charger termination, recharge and thermal qualification control
module charger_termination_control #(
  parameter int unsigned TERM_TICKS = chg_pkg::TERM_TICKS,
  parameter int unsigned TRKL_TICKS = chg_pkg::TRKL_TICKS,
  parameter int unsigned TICK_HI = chg_pkg::TICK_CYC_HI,
  parameter int unsigned TICK_LO = chg_pkg::TICK_CYC_LO
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration pins
  input wire logic freq_hi,
  input wire logic run,
  // Analog comparator inputs
  input wire logic float_reached,
  input wire logic below_recharge,
  input wire logic below_c10,
  input wire logic below_trickle,
  input wire logic cc_mode,
  input wire logic batt_present,
  input wire logic hot,
  input wire logic cold,
  input wire logic thermal_disable,
  // Power stage status
  input wire logic hs_on,
  input wire logic cycle_start,
  // Indicators (open drain, low active)
  output logic charge_active_n_o,
  output logic charge_active_n_oe,
  output logic fault_n_o,
  output logic fault_n_oe,
  // Power stage controls
  output logic pause,
  output logic terminate,
  output logic force_ls,
  output logic clamp_trickle
);
  // Timer width holds the two-hour count at the default tick
  localparam int TW = 28;

  // Two-flop synchronisers for all pin-side inputs but cycle_start, which gets one flop
  localparam int NS = 12;
  logic [NS-1:0] raw_in, s1_ff, s2_ff;
  assign raw_in = {freq_hi, run, float_reached, below_recharge, below_c10,
    below_trickle, cc_mode, batt_present, hot, cold, thermal_disable, hs_on};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
    end
  end
  logic f_hi, f_run, f_float, f_rchg, f_c10, f_trkl, f_cc, f_bat;
  logic f_hot, f_cold, f_dis, f_hs;
  assign {f_hi, f_run, f_float, f_rchg, f_c10, f_trkl, f_cc, f_bat,
    f_hot, f_cold, f_dis, f_hs} = s2_ff;

  // Dropout detector on the switching cycles
  logic cs_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cs_ff <= 1'b0;
    else cs_ff <= cycle_start;
  end
  dropout_detect #(.LIMIT(chg_pkg::DROPOUT_CYC)) u_dropout (
    .clk(clk),
    .arst_n(arst_n),
    .hs_on(f_hs),
    .cycle_start(cs_ff),
    .force_ls(force_ls)
  );

  // Prescaler; tick width fixed in time for either frequency
  logic [7:0] pre_ff, nxt_pre;
  logic tick;
  always_comb begin
    tick = 1'b0;
    nxt_pre = pre_ff + 8'h01;
    if (pre_ff >= 8'(f_hi ? TICK_HI - 1 : TICK_LO - 1)) begin
      nxt_pre = 8'h00;
      tick = 1'b1;
    end
  end

  // State, termination timer and filters
  chg_pkg::chg_state_t st_ff, nxt_st;
  logic [TW-1:0] term_ff, nxt_term, trkl_ff, nxt_trkl;
  logic [4:0] rf_ff, nxt_rf, cf_ff, nxt_cf;
  logic rchg_prev_ff, c10_ff, nxt_c10, armed_ff, nxt_armed;
  logic therm_fault;

  // Thermal fault only counts when qualification is enabled
  assign therm_fault = !f_dis && (f_hot || f_cold);

  always_comb begin
    nxt_st = st_ff;
    nxt_term = term_ff;
    nxt_trkl = trkl_ff;
    nxt_rf = rf_ff;
    nxt_cf = cf_ff;
    nxt_c10 = c10_ff;
    nxt_armed = armed_ff;
    // C/10 filter on the program node comparator
    if (!f_c10) begin
      nxt_cf = 5'h00;
      nxt_c10 = 1'b0;
    end else if (tick && !c10_ff) begin
      if (cf_ff >= 5'(chg_pkg::C10_TICKS - 1)) nxt_c10 = 1'b1;
      else nxt_cf = cf_ff + 5'h01;
    end
    unique case (st_ff)
      chg_pkg::ST_WAIT: begin
        if (f_run && f_bat) nxt_st = chg_pkg::ST_TRKL;
        nxt_term = '0;
        nxt_trkl = '0;
        nxt_armed = 1'b0;
      end
      chg_pkg::ST_TRKL: begin
        if (!f_trkl) nxt_st = chg_pkg::ST_CHG;
        else if (tick && !therm_fault) begin
          if (trkl_ff >= TW'(TRKL_TICKS - 1)) nxt_st = chg_pkg::ST_BAD;
          else nxt_trkl = trkl_ff + 1'b1;
        end
      end
      chg_pkg::ST_CHG: begin
        if (f_float) nxt_armed = 1'b1;
        if (f_rchg != rchg_prev_ff) begin
          nxt_term = '0;
        end else if (tick && armed_ff && !f_cc && !therm_fault) begin
          if (term_ff >= TW'(TERM_TICKS - 1)) begin
            nxt_st = chg_pkg::ST_SLEEP;
            nxt_rf = 5'h00;
          end else nxt_term = term_ff + 1'b1;
        end
      end
      chg_pkg::ST_SLEEP: begin
        // Filter ignores short load transients
        if (!f_rchg) nxt_rf = 5'h00;
        else if (tick) begin
          if (rf_ff >= 5'(chg_pkg::RCHG_TICKS - 1)) begin
            nxt_st = chg_pkg::ST_CHG;
            nxt_term = '0;
            nxt_armed = 1'b0;
          end else nxt_rf = rf_ff + 5'h01;
        end
      end
      chg_pkg::ST_BAD: begin
        // Removal of the battery clears the fault
        if (!f_bat) nxt_st = chg_pkg::ST_WAIT;
      end
      default: nxt_st = chg_pkg::ST_WAIT;
    endcase
    if (!f_run) nxt_st = chg_pkg::ST_WAIT;
  end

  // Registered outputs
  logic chg_n_ff, flt_n_ff, pause_ff, term_o_ff, clamp_ff;
  logic nxt_chg_n, nxt_flt_n, nxt_pause, nxt_term_o, nxt_clamp;
  always_comb begin
    nxt_chg_n = 1'b1;
    nxt_flt_n = 1'b1;
    // Pause only while charging, so it never disagrees with the flags
    nxt_pause = 1'b0;
    nxt_term_o = 1'b0;
    nxt_clamp = (nxt_st == chg_pkg::ST_TRKL);
    unique case (nxt_st)
      chg_pkg::ST_TRKL, chg_pkg::ST_CHG: begin
        nxt_pause = therm_fault;
        nxt_chg_n = nxt_c10 && !therm_fault;
        nxt_flt_n = !therm_fault;
      end
      chg_pkg::ST_BAD: begin
        nxt_flt_n = 1'b0;
        nxt_term_o = 1'b1;
      end
      default: nxt_term_o = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 8'h00;
      st_ff <= chg_pkg::ST_WAIT;
      term_ff <= '0;
      trkl_ff <= '0;
      rf_ff <= 5'h00;
      cf_ff <= 5'h00;
      c10_ff <= 1'b0;
      armed_ff <= 1'b0;
      rchg_prev_ff <= 1'b0;
      chg_n_ff <= 1'b1;
      flt_n_ff <= 1'b1;
      pause_ff <= 1'b0;
      term_o_ff <= 1'b1;
      clamp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      st_ff <= nxt_st;
      term_ff <= nxt_term;
      trkl_ff <= nxt_trkl;
      rf_ff <= nxt_rf;
      cf_ff <= nxt_cf;
      c10_ff <= nxt_c10;
      armed_ff <= nxt_armed;
      rchg_prev_ff <= f_rchg;
      chg_n_ff <= nxt_chg_n;
      flt_n_ff <= nxt_flt_n;
      pause_ff <= nxt_pause;
      term_o_ff <= nxt_term_o;
      clamp_ff <= nxt_clamp;
    end
  end

  // Open drain: data low always, enable when pulling low
  assign charge_active_n_o = 1'b0;
  assign charge_active_n_oe = !chg_n_ff;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = !flt_n_ff;
  assign pause = pause_ff;
  assign terminate = term_o_ff;
  assign clamp_trickle = clamp_ff;
endmodule

//--- hdl/chg_pkg.sv
// Package of constants for the charger termination control
package chg_pkg;
  // Switching clock rate in Hz for each frequency selection
  localparam int unsigned FOSC_HI_HZ = 1500000;
  localparam int unsigned FOSC_LO_HZ = 750000;
  // Prescaler tick width, in microseconds
  localparam int unsigned TICK_US = 50;
  // Multiply first: dividing first drops half a cycle per microsecond at the high rate and 0.75 at the low
  localparam int unsigned TICK_CYC_HI = (FOSC_HI_HZ * TICK_US) / 1000000;
  localparam int unsigned TICK_CYC_LO =
    (FOSC_LO_HZ * TICK_US) / 1000000;
  // Intervals in their own units
  localparam int unsigned TERM_TIME_MIN = 120;
  localparam int unsigned TRKL_TIME_MIN = 30;
  localparam int unsigned RCHG_FILT_US = 500;
  localparam int unsigned C10_FILT_US = 350;
  // Interval lengths in ticks; recharge filter rounds its least time up, C/10 filter adds a tick to its least time
  // Ticks per second taken first so the product stays inside 32 bits
  localparam int unsigned TERM_TICKS = TERM_TIME_MIN * 60 * (1000000 / TICK_US);
  localparam int unsigned TRKL_TICKS = TRKL_TIME_MIN * 60 * (1000000 / TICK_US);
  localparam int unsigned RCHG_TICKS = (RCHG_FILT_US + TICK_US - 1) / TICK_US;
  localparam int unsigned C10_TICKS = (C10_FILT_US + TICK_US) / TICK_US;
  // Dropout detection: high-side on-cycles before forcing low side
  localparam int unsigned DROPOUT_CYC = 8;
  // Charger states
  typedef enum logic [4:0] {
    ST_TRKL  = 5'b00001,
    ST_CHG   = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_BAD   = 5'b01000,
    ST_WAIT  = 5'b10000
  } chg_state_t;
endpackage

//--- hdl/dropout_detect.sv
// Dropout detector counting high-side on cycles
module dropout_detect #(
  parameter int unsigned LIMIT = chg_pkg::DROPOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Switch status (synchronised)
  input wire logic hs_on,
  input wire logic cycle_start,
  // Force low-side switch
  output logic force_ls
);
  logic [3:0] cnt_ff, nxt_cnt;
  logic force_ff, nxt_force;

  // Count consecutive cycles with high side held on
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_force = force_ff;
    if (!hs_on) begin
      nxt_cnt = 4'h0;
      nxt_force = 1'b0;
    end else if (cycle_start) begin
      nxt_force = 1'b0;
      if (cnt_ff == 4'(LIMIT - 1)) begin
        nxt_cnt = 4'h0;
        nxt_force = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
      force_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      force_ff <= nxt_force;
    end
  end

  assign force_ls = force_ff;
endmodule

//--- test/chg_properties.sv
// Port checker for the charger termination control
module chg_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Observed inputs
  input wire logic hot,
  input wire logic cold,
  input wire logic thermal_disable,
  input wire logic hs_on,
  // Observed outputs
  input wire logic charge_active_n_oe,
  input wire logic fault_n_oe,
  input wire logic pause,
  input wire logic terminate,
  input wire logic force_ls,
  input wire logic clamp_trickle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Five edges allow for sync flops plus the output register
  drop_release_a:
    assert property (!hs_on[*5] |=> !force_ls) else $error("force_ls");
  therm_bypass_a:
    assert property (thermal_disable[*5] |=> !pause) else $error("pause");
  therm_clear_a:
    assert property ((!hot && !cold)[*5] |=> !pause) else $error("pause");
  thermal_flags_a:
    assert property (pause |-> fault_n_oe && charge_active_n_oe)
    else $error("thermal flags");
  bad_batt_a:
    assert property (fault_n_oe && !pause |-> terminate
      && !charge_active_n_oe) else $error("bad battery flags");
  trickle_clamp_a:
    assert property (clamp_trickle |-> !terminate) else $error("clamp");
  charging_live_a:
    assert property (charge_active_n_oe && !pause |-> !terminate)
    else $error("charging while stopped");
  reset_idle_a:
    assert property ($rose(arst_n) |-> terminate && !pause && !force_ls)
    else $error("reset values");
  // Main scenarios
  cover property (force_ls);
  cover property (pause);
  cover property (fault_n_oe && !pause);
endmodule

bind charger_termination_control chg_properties u_props (.clk, .arst_n,
  .hot, .cold, .thermal_disable, .hs_on, .charge_active_n_oe,
  .fault_n_oe, .pause, .terminate, .force_ls, .clamp_trickle);

//--- test/chg_partner.sv
// Pull-ups and thermistor comparators beside the charger
module chg_partner (
  // Open-drain drive from the charger
  input wire logic chg_o,
  input wire logic chg_oe,
  input wire logic flt_o,
  input wire logic flt_oe,
  // Temperature class: 0 safe, 1 hot, 2 cold
  input wire logic [1:0] temp,
  // Resolved pins and comparators
  output logic chg_pin,
  output logic flt_pin,
  output logic hot,
  output logic cold
);
  // Pull-up wins unless the pin is sunk
  assign chg_pin = chg_oe ? chg_o : 1'h1;
  assign flt_pin = flt_oe ? flt_o : 1'h1;
  // One battery cannot be hot and cold at once
  assign hot = (temp == 2'h1);
  assign cold = (temp == 2'h2);
endmodule

//--- test/tb_top.sv
// Directed bench for the charger termination control
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, arst_n = 1'h0, freq_hi = 1'h1, run = 1'h1;
  logic float_reached = 1'h0, below_recharge = 1'h0, below_c10 = 1'h0;
  logic below_trickle = 1'h0, cc_mode = 1'h1, batt_present = 1'h1;
  logic thermal_disable = 1'h0, hs_on = 1'h0, cycle_start = 1'h0;
  logic [1:0] temp = 2'h0;
  logic hot, cold, chg_o, chg_oe, flt_o, flt_oe, chg_pin, flt_pin;
  logic pause, terminate, force_ls, clamp_trickle;
  int bad_count = 0;
  int compares = 0;
  // 8 ns clock
  always #4 clk = ~clk;
  // Short timers: 20 and 10 ticks of 4 or 2 cycles
  charger_termination_control #(.TERM_TICKS(20), .TRKL_TICKS(10),
    .TICK_HI(4), .TICK_LO(2)) dut (.clk, .arst_n, .freq_hi, .run,
    .float_reached, .below_recharge, .below_c10, .below_trickle,
    .cc_mode, .batt_present, .hot, .cold, .thermal_disable, .hs_on,
    .cycle_start, .charge_active_n_o(chg_o), .charge_active_n_oe(chg_oe),
    .fault_n_o(flt_o), .fault_n_oe(flt_oe), .pause, .terminate,
    .force_ls, .clamp_trickle);
  chg_partner batt (.chg_o, .chg_oe, .flt_o, .flt_oe, .temp, .chg_pin,
    .flt_pin, .hot, .cold);
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Single compare for every one-bit result
  task automatic chk(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Bounded wait on a pin, then compare
  task automatic wfor(input string nm, input logic e, input int n);
    logic g;
    for (int i = 0; i <= n; i++) begin
      g = nm == "chg_pin" ? chg_pin : nm == "flt_pin" ? flt_pin : terminate;
      if (g === e) break;
      @(negedge clk);
    end
    chk(nm, e, g);
  endtask
  task automatic conclude;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Tests take about 510 cycles
  initial begin
    #80000;
    bad_count++;
    conclude();
  end
  initial begin
    cyc(5);
    arst_n = 1'h1;
    cyc(12);
    chk("clamp_trickle", 1'h0, clamp_trickle);
    // Seven starts with the high side on stay quiet
    // Let the synchronised high-side level settle before the first start
    hs_on = 1'h1;
    cyc(3);
    for (int i = 1; i <= 8; i++) begin
      cycle_start = 1'h1;
      cyc(1);
      cycle_start = 1'h0;
      cyc(5);
      chk("force_ls", i == 8, force_ls);
    end
    hs_on = 1'h0;
    cyc(6);
    chk("force_ls", 1'h0, force_ls);
    $display("dropout test done");
    // Hot, then cold; bypass lifts the pause
    for (int t = 1; t <= 2; t++) begin
      temp = 2'(t);
      cyc(6);
      chk("pause", 1'h1, pause);
      chk("flt_pin", 1'h0, flt_pin);
      chk("chg_pin", 1'h0, chg_pin);
      thermal_disable = 1'h1;
      cyc(6);
      chk("pause", 1'h0, pause);
      thermal_disable = 1'h0;
      temp = 2'h0;
      cyc(6);
      chk("pause", 1'h0, pause);
    end
    $display("thermal test done");
    float_reached = 1'h1;
    cyc(150);
    chk("terminate", 1'h0, terminate);
    cc_mode = 1'h0;
    below_c10 = 1'h1;
    cyc(20);
    chk("chg_pin", 1'h0, chg_pin);
    wfor("chg_pin", 1'h1, 30);
    chk("terminate", 1'h0, terminate);
    // Past C/10 a thermal fault must still pull the charge pin low
    temp = 2'h1;
    cyc(6);
    chk("chg_pin", 1'h0, chg_pin);
    temp = 2'h0;
    cyc(14);
    // Crossing near expiry restarts the full count
    below_recharge = 1'h1;
    cyc(2);
    below_recharge = 1'h0;
    cyc(60);
    chk("terminate", 1'h0, terminate);
    wfor("terminate", 1'h1, 60);
    $display("timer test done");
    below_recharge = 1'h1;
    cyc(20);
    below_recharge = 1'h0;
    cyc(20);
    chk("terminate", 1'h1, terminate);
    below_recharge = 1'h1;
    wfor("terminate", 1'h0, 60);
    below_recharge = 1'h0;
    $display("recharge test done");
    // Slow clock halves the trickle timeout
    // Run low is the way back to idle once charging has begun
    freq_hi = 1'h0;
    run = 1'h0;
    below_trickle = 1'h1;
    cyc(8);
    run = 1'h1;
    cyc(8);
    chk("clamp_trickle", 1'h1, clamp_trickle);
    wfor("flt_pin", 1'h0, 30);
    chk("chg_pin", 1'h1, chg_pin);
    chk("terminate", 1'h1, terminate);
    batt_present = 1'h0;
    wfor("flt_pin", 1'h1, 10);
    $display("bad battery test done");
    conclude();
  end
endmodule
